// ### hdl/mic_detect.sv
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps

// Summary of operation
// - Hookswitch signalled after ten consecutive short measurements.
// - Current above detect threshold means insertion.
// - Polarity zero: insertion sets insertion status.
// - Polarity one: removal sets insertion status.
// - Current above short threshold means hookswitch.
// - Polarity zero: filtered press sets hookswitch status.
// - Polarity one: release sets hookswitch status.
// - Insertion events reported within detection delay.
// - Filter runs only with clock source and enable.
// - Filter also needs a servo channel enabled.
// - Events during stopped clocks reported on resume.
// - Pin shows detector state with same delay.
// - Detection only while detect enable set.
module mic_detect #(
	parameter int HOOK_COUNT  = mic_detect_pkg::HOOK_COUNT,
	parameter int MEAS_CYCLES = mic_detect_pkg::MEAS_CYCLES
) (
	input  wire logic                               clk_in,
	input  wire logic                               rst_in,
	input  wire logic                               mclk_present_in,
	input  wire logic                               det_cmp_in,
	input  wire logic                               short_cmp_in,
	input  wire logic [mic_detect_pkg::ADDR_W-1:0]  addr_in,
	input  wire logic [mic_detect_pkg::DATA_W-1:0]  wdata_in,
	input  wire logic                               wr_in,
	input  wire logic                               rd_in,
	output logic      [mic_detect_pkg::DATA_W-1:0]  rdata_out,
	output logic      [2:0]                         current_detect_threshold_out,
	output logic      [1:0]                         short_circuit_threshold_out,
	output logic                                    current_detect_enable_out,
	output logic                                    gpio_state_out,
	output logic                                    irq_out
);

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic       mclk_ok;
	logic       det_raw;
	logic       short_raw;

	// Two stages for each comparator and the clock-present pin.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {mclk_present_in, short_cmp_in, det_cmp_in};
			sync2_q <= sync1_q;
		end
	end

	assign det_raw   = sync2_q[0];
	assign short_raw = sync2_q[1];
	assign mclk_ok   = sync2_q[2];

	// ==========================================================
	// Registers
	// ==========================================================
	logic [15:0] ctrl_q;
	logic [15:0] ctrl_d;
	logic [15:0] clocks_q;
	logic [15:0] clocks_d;
	logic [1:0]  status_q;
	logic [1:0]  status_d;
	logic [1:0]  mask_q;
	logic [1:0]  mask_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic [1:0]  event_set;
	logic        ins_state;
	logic        hook_state;

	// Bus writes, write-one-to-clear status with set winning, and read capture.
	always_comb begin
		ctrl_d   = ctrl_q;
		clocks_d = clocks_q;
		mask_d   = mask_q;
		status_d = status_q;
		rdata_d  = 16'h0000;
		if (wr_in) begin
			unique case (addr_in)
				mic_detect_pkg::ADDR_CTRL: begin
					ctrl_d = wdata_in;
				end
				mic_detect_pkg::ADDR_CLOCKS: begin
					clocks_d = wdata_in;
				end
				mic_detect_pkg::ADDR_STATUS: begin
					status_d = status_q & ~wdata_in[mic_detect_pkg::EV_W-1:0];
				end
				mic_detect_pkg::ADDR_MASK: begin
					mask_d = wdata_in[mic_detect_pkg::EV_W-1:0];
				end
				default: begin
				end
			endcase
		end
		status_d = status_d | event_set;
		if (rd_in) begin
			unique case (addr_in)
				mic_detect_pkg::ADDR_CTRL: begin
					rdata_d = ctrl_q;
				end
				mic_detect_pkg::ADDR_CLOCKS: begin
					rdata_d = clocks_q;
				end
				mic_detect_pkg::ADDR_STATUS: begin
					rdata_d = {14'h0000, status_q};
				end
				mic_detect_pkg::ADDR_MASK: begin
					rdata_d = {14'h0000, mask_q};
				end
				mic_detect_pkg::ADDR_STATE: begin
					rdata_d = {14'h0000, hook_state, ins_state};
				end
				default: begin
					rdata_d = 16'h0000;
				end
			endcase
		end
	end

	// Registers the register file.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_q   <= mic_detect_pkg::CTRL_RESET;
			clocks_q <= mic_detect_pkg::CLOCKS_RESET;
			status_q <= 2'h0;
			mask_q   <= mic_detect_pkg::MASK_RESET;
			rdata_q  <= 16'h0000;
		end else begin
			ctrl_q   <= ctrl_d;
			clocks_q <= clocks_d;
			status_q <= status_d;
			mask_q   <= mask_d;
			rdata_q  <= rdata_d;
		end
	end

	assign rdata_out = rdata_q;
	assign current_detect_threshold_out =
		ctrl_q[mic_detect_pkg::CTRL_DET_LSB +: mic_detect_pkg::CTRL_DET_W];
	assign short_circuit_threshold_out =
		ctrl_q[mic_detect_pkg::CTRL_SHORT_LSB +: mic_detect_pkg::CTRL_SHORT_W];
	assign current_detect_enable_out = ctrl_q[mic_detect_pkg::CTRL_ENA_BIT];

	// ==========================================================
	// Run condition and measurement tick
	// ==========================================================
	logic        det_ena;
	logic        clk_source;
	logic        run;
	logic [15:0] tick_q;
	logic [15:0] tick_d;
	logic        sample;

	assign det_ena    = ctrl_q[mic_detect_pkg::CTRL_ENA_BIT];
	assign clk_source = mclk_ok | clocks_q[mic_detect_pkg::CLK_SRC_BIT];
	assign run = det_ena & clk_source & clocks_q[mic_detect_pkg::SYSTEM_CLOCK_ENABLE_BIT]
		& (|clocks_q[mic_detect_pkg::DCS_LSB +: mic_detect_pkg::DCS_W]);

	// The tick counter freezes while stopped, so comparator levels are judged on resume.
	always_comb begin
		tick_d = tick_q;
		sample = 1'b0;
		if (run) begin
			if (tick_q == 16'(MEAS_CYCLES - 1)) begin
				tick_d = 16'h0000;
				sample = 1'b1;
			end else begin
				tick_d = tick_q + 16'h0001;
			end
		end
	end

	// Registers the tick counter.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tick_q <= 16'h0000;
		end else begin
			tick_q <= tick_d;
		end
	end

	// ==========================================================
	// Detectors
	// ==========================================================
	logic ins_q;
	logic hook_q;
	logic ins_d;

	// Insertion follows the comparator at each measurement.
	always_comb begin
		ins_d = ins_q;
		if (!det_ena) begin
			ins_d = 1'b0;
		end else if (sample) begin
			ins_d = det_raw;
		end
	end

	// The hookswitch state passes the consecutive-measurement filter.
	cons_filter #(
		.COUNT(HOOK_COUNT)
	) u_hook_filter (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.sample_in(sample),
		.raw_in   (short_raw),
		.clear_in (~det_ena),
		.state_out(hook_state)
	);

	// Registers the previous states for edge detection.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ins_q  <= 1'b0;
			hook_q <= 1'b0;
		end else begin
			ins_q  <= ins_d;
			hook_q <= hook_state;
		end
	end

	assign ins_state = ins_q;

	// Polarity picks which edge of each state raises its event.
	always_comb begin
		event_set = 2'h0;
		if (ctrl_q[mic_detect_pkg::CTRL_INS_POL]) begin
			event_set[mic_detect_pkg::EV_INS] = ins_q & ~ins_d;
		end else begin
			event_set[mic_detect_pkg::EV_INS] = ~ins_q & ins_d;
		end
		if (ctrl_q[mic_detect_pkg::CTRL_HOOK_POL]) begin
			event_set[mic_detect_pkg::EV_HOOK] = hook_q & ~hook_state;
		end else begin
			event_set[mic_detect_pkg::EV_HOOK] = ~hook_q & hook_state;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// The pin shows the same registered state the events are built from.
	assign gpio_state_out = ctrl_q[mic_detect_pkg::CTRL_GPIO_SEL] ? hook_q : ins_q;
	assign irq_out = |(status_q & mask_q);

	// ==========================================================
	// Checks
	// ==========================================================
	chk_ins_rise_set: assert property (@(posedge clk_in) disable iff (rst_in)
		(!ctrl_q[mic_detect_pkg::CTRL_INS_POL] && $rose(ins_q))
		|-> status_q[mic_detect_pkg::EV_INS])
		else $error("Insertion did not set its status.");

	chk_ins_fall_set: assert property (@(posedge clk_in) disable iff (rst_in)
		(ctrl_q[mic_detect_pkg::CTRL_INS_POL] && $stable(ctrl_q) && $fell(ins_q))
		|-> status_q[mic_detect_pkg::EV_INS])
		else $error("Removal did not set its status.");

	chk_hook_press_set: assert property (@(posedge clk_in) disable iff (rst_in)
		(!ctrl_q[mic_detect_pkg::CTRL_HOOK_POL] && $rose(hook_q))
		|-> status_q[mic_detect_pkg::EV_HOOK])
		else $error("Hookswitch press did not set its status.");

	chk_hook_rel_set: assert property (@(posedge clk_in) disable iff (rst_in)
		(ctrl_q[mic_detect_pkg::CTRL_HOOK_POL] && $stable(ctrl_q) && $fell(hook_q))
		|-> status_q[mic_detect_pkg::EV_HOOK])
		else $error("Hookswitch release did not set its status.");

	chk_stopped_no_tick: assert property (@(posedge clk_in) disable iff (rst_in)
		(!run && det_ena) |=> ($stable(tick_q) && $stable(ins_q)))
		else $error("Measurement taken while clocking unmet.");

	chk_servo_needed: assert property (@(posedge clk_in) disable iff (rst_in)
		(clocks_q[mic_detect_pkg::DCS_LSB +: mic_detect_pkg::DCS_W] == 4'h0) |=> $stable(tick_q))
		else $error("Tick advanced without a servo channel.");

	chk_disable_clears: assert property (@(posedge clk_in) disable iff (rst_in)
		!det_ena |=> !ins_q)
		else $error("Detector state held while disabled.");

	chk_status_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
		(status_q[0] && !(wr_in && addr_in == mic_detect_pkg::ADDR_STATUS)) |=> status_q[0])
		else $error("Status bit dropped without a clear.");

	chk_irq_level: assert property (@(posedge clk_in) disable iff (rst_in)
		((|(event_set & mask_q)) && !wr_in) |=> irq_out)
		else $error("Unmasked event did not raise the interrupt.");

endmodule // mic_detect

// ### hdl/mic_detect_pkg.sv
package mic_detect_pkg;

	// ==========================================================
	// Register map
	// ==========================================================
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_CLOCKS = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_MASK   = 4'h3;
	localparam logic [3:0] ADDR_STATE  = 4'h4;

	// ==========================================================
	// Control register fields
	// ==========================================================
	localparam int CTRL_ENA_BIT    = 1;
	localparam int CTRL_SHORT_LSB  = 2;
	localparam int CTRL_SHORT_W    = 2;
	localparam int CTRL_DET_LSB    = 4;
	localparam int CTRL_DET_W      = 3;
	localparam int CTRL_INS_POL    = 8;
	localparam int CTRL_HOOK_POL   = 9;
	localparam int CTRL_GPIO_SEL   = 10;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// ==========================================================
	// Clock register fields
	// ==========================================================
	localparam int SYSTEM_CLOCK_ENABLE_BIT = 0;
	localparam int CLK_SRC_BIT     = 1;
	localparam int DCS_LSB         = 4;
	localparam int DCS_W           = 4;
	localparam logic [15:0] CLOCKS_RESET = 16'h0000;

	// ==========================================================
	// Status and mask fields
	// ==========================================================
	localparam int EV_INS   = 0;
	localparam int EV_HOOK  = 1;
	localparam int EV_W     = 2;
	localparam logic [1:0] MASK_RESET = 2'h3;

	// ==========================================================
	// Filter and timing
	// ==========================================================
	localparam int HOOK_COUNT     = 10;
	localparam int MEAS_PERIOD_NS = 1000;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int MEAS_CYCLES    = MEAS_PERIOD_NS / CLK_PERIOD_NS;

endpackage

// ### hdl/cons_filter.sv
`timescale 1ns/10ps

// Counts consecutive samples that disagree with the held state and updates a filtered state.
module cons_filter #(
	parameter int COUNT = 10
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic sample_in,
	input  wire logic raw_in,
	input  wire logic clear_in,
	output logic      state_out
);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       state_q;
	logic       state_d;

	// A sample that disagrees with the held state counts up; agreement restarts.
	always_comb begin
		cnt_d   = cnt_q;
		state_d = state_q;
		if (clear_in) begin
			cnt_d   = 8'h00;
			state_d = 1'b0;
		end else if (sample_in) begin
			if (raw_in == state_q) begin
				cnt_d = 8'h00;
			end else if (cnt_q == 8'(COUNT - 1)) begin
				cnt_d   = 8'h00;
				state_d = raw_in;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
		end
	end

	// Registers the filter state.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q   <= 8'h00;
			state_q <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			state_q <= state_d;
		end
	end

	assign state_out = state_q;

	// ==========================================================
	// Checks
	// ==========================================================
	chk_filter_count: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(state_q) |-> $past(cnt_q) == 8'(COUNT - 1))
		else $error("Filter changed state before the full sample count.");

endmodule // cons_filter

// ### test/mic_bias_model.sv
`timescale 1ns/10ps

// ==========================================================
// Bias current comparators
// ==========================================================
// Stands in for the two analogue threshold comparators; current is in microamps.
module mic_bias_model (
	input  wire logic        enable_in,
	input  wire logic [2:0]  det_thr_in,
	input  wire logic [1:0]  short_thr_in,
	input  wire logic [10:0] current_in,
	output logic             det_cmp_out,
	output logic             short_cmp_out
);
	// Each level follows its code; a disabled detector reports nothing.
	always_comb begin
		det_cmp_out   = enable_in && (current_in > 11'h046 + 11'h0BE * det_thr_in);
		short_cmp_out = enable_in && (current_in > 11'h208 + 11'h168 * short_thr_in);
	end
endmodule // mic_bias_model

// ### test/test_mic_detect.sv
`timescale 1ns/10ps

// ==========================================================
// Bench for the bias current event logic
// ==========================================================
module test_mic_detect;
	logic        clk_in = 0;
	logic        rst_in = 1;
	logic        mclk   = 1;
	logic        det_cmp;
	logic        short_cmp;
	logic [3:0]  addr   = 4'h0;
	logic [15:0] wdata  = 16'h0000;
	logic        wr     = 0;
	logic        rd     = 0;
	logic [15:0] rdata;
	logic [2:0]  det_thr;
	logic [1:0]  short_thr;
	logic        det_ena;
	logic        gpio;
	logic        irq;
	logic [10:0] current = 11'h000;
	int          failures = 0;
	int          num_checks = 0;
	int          cycles = 0;

	mic_detect #(.HOOK_COUNT(10), .MEAS_CYCLES(4)) DUT (
		.clk_in(clk_in), .rst_in(rst_in), .mclk_present_in(mclk), .det_cmp_in(det_cmp),
		.short_cmp_in(short_cmp), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .current_detect_threshold_out(det_thr),
		.short_circuit_threshold_out(short_thr), .current_detect_enable_out(det_ena),
		.gpio_state_out(gpio), .irq_out(irq));

	mic_bias_model partner (
		.enable_in(det_ena), .det_thr_in(det_thr), .short_thr_in(short_thr),
		.current_in(current), .det_cmp_out(det_cmp), .short_cmp_out(short_cmp));

	// Free-running 100 MHz clock.
	always #5 clk_in = ~clk_in;

	// Cuts a hung run short.
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: %s", $time, what);
		end
	endtask

	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr  <= a;
		wdata <= d;
		wr    <= 1;
		@(posedge clk_in);
		wr    <= 0;
	endtask

	// Read data are taken in the one cycle after the strobe.
	task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input string what);
		@(posedge clk_in);
		addr <= a;
		rd   <= 1;
		@(posedge clk_in);
		rd   <= 0;
		#1 check(rdata, exp, what);
	endtask

	task automatic wait_irq(input int max);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < max) begin
			@(posedge clk_in);
			#1;
			n++;
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic t_reset();
		rchk(mic_detect_pkg::ADDR_CTRL, 16'h0000, "ctrl reset");
		rchk(mic_detect_pkg::ADDR_CLOCKS, 16'h0000, "clocks reset");
		rchk(mic_detect_pkg::ADDR_STATUS, 16'h0000, "status reset");
		rchk(mic_detect_pkg::ADDR_MASK, 16'h0003, "mask reset");
		rchk(4'hF, 16'h0000, "unmapped read");
		check({15'h0000, irq}, 16'h0000, "irq reset");
		$display("test reset done");
	endtask

	task automatic t_insert();
		wreg(mic_detect_pkg::ADDR_CTRL, 16'h0002);
		wreg(mic_detect_pkg::ADDR_CLOCKS, 16'h0011);
		current <= 11'h064;
		wait_irq(20);
		check({15'h0000, irq}, 16'h0001, "insert irq");
		check({15'h0000, gpio}, 16'h0001, "insert pin");
		rchk(mic_detect_pkg::ADDR_STATUS, 16'h0001, "insert status");
		idle(20);
		check({15'h0000, gpio}, 16'h0001, "pin settled");
		rchk(mic_detect_pkg::ADDR_STATUS, 16'h0001, "sticky status");
		wreg(mic_detect_pkg::ADDR_STATUS, 16'h0001);
		rchk(mic_detect_pkg::ADDR_STATUS, 16'h0000, "status cleared");
		$display("test insert done");
	endtask

	task automatic t_remove();
		idle(30);
		wreg(mic_detect_pkg::ADDR_CTRL, 16'h0102);
		current <= 11'h000;
		wait_irq(20);
		rchk(mic_detect_pkg::ADDR_STATUS, 16'h0001, "removal status");
		wreg(mic_detect_pkg::ADDR_STATUS, 16'h0001);
		idle(30);
		wreg(mic_detect_pkg::ADDR_CTRL, 16'h0402);
		current <= 11'h064;
		wait_irq(20);
		rchk(mic_detect_pkg::ADDR_STATUS, 16'h0001, "insertion again");
		wreg(mic_detect_pkg::ADDR_STATUS, 16'h0001);
		$display("test removal done");
	endtask

	// Hook press with an interrupted run of samples, then the release.
	task automatic t_hook();
		current <= 11'h258;
		idle(24);
		current <= 11'h064;
		idle(8);
		current <= 11'h258;
		idle(35);
		check({15'h0000, gpio}, 16'h0000, "hook too early");
		wait_irq(30);
		check({15'h0000, gpio}, 16'h0001, "hook pin");
		rchk(mic_detect_pkg::ADDR_STATUS, 16'h0002, "hook status");
		wreg(mic_detect_pkg::ADDR_STATUS, 16'h0002);
		wreg(mic_detect_pkg::ADDR_CTRL, 16'h0602);
		current <= 11'h064;
		idle(35);
		check({15'h0000, irq}, 16'h0000, "release too early");
		wait_irq(30);
		rchk(mic_detect_pkg::ADDR_STATUS, 16'h0002, "release status");
		wreg(mic_detect_pkg::ADDR_STATUS, 16'h0002);
		$display("test hook done");
	endtask

	// Each case breaks one clocking condition, then restores it.
	task automatic t_gated();
		logic [15:0] clk_case [3] = '{16'h0010, 16'h0001, 16'h0011};
		wreg(mic_detect_pkg::ADDR_CTRL, 16'h0002);
		for (int i = 0; i < 3; i++) begin
			current <= 11'h000;
			idle(12);
			wreg(mic_detect_pkg::ADDR_CLOCKS, clk_case[i]);
			mclk <= (i != 2);
			current <= 11'h064;
			idle(40);
			check({15'h0000, irq}, 16'h0000, "event while stopped");
			wreg(mic_detect_pkg::ADDR_CLOCKS, 16'h0011);
			mclk <= 1;
			wait_irq(20);
			rchk(mic_detect_pkg::ADDR_STATUS, 16'h0001, "event on resume");
			wreg(mic_detect_pkg::ADDR_STATUS, 16'h0001);
		end
		// The free-running loop source keeps the filter alive without the master clock.
		wreg(mic_detect_pkg::ADDR_CLOCKS, 16'h0013);
		mclk    <= 0;
		current <= 11'h000;
		idle(12);
		current <= 11'h064;
		wait_irq(20);
		rchk(mic_detect_pkg::ADDR_STATUS, 16'h0001, "free-running source");
		wreg(mic_detect_pkg::ADDR_STATUS, 16'h0001);
		wreg(mic_detect_pkg::ADDR_CLOCKS, 16'h0011);
		mclk <= 1;
		$display("test gated done");
	endtask

	task automatic t_mask_enable();
		current <= 11'h000;
		idle(12);
		wreg(mic_detect_pkg::ADDR_MASK, 16'h0000);
		current <= 11'h064;
		idle(20);
		check({15'h0000, irq}, 16'h0000, "masked irq");
		rchk(mic_detect_pkg::ADDR_STATUS, 16'h0001, "masked status");
		wreg(mic_detect_pkg::ADDR_MASK, 16'h0003);
		idle(1);
		check({15'h0000, irq}, 16'h0001, "unmasked irq");
		wreg(mic_detect_pkg::ADDR_CTRL, 16'h0000);
		wreg(mic_detect_pkg::ADDR_STATUS, 16'h0003);
		current <= 11'h258;
		idle(60);
		rchk(mic_detect_pkg::ADDR_STATUS, 16'h0000, "disabled detect");
		rchk(mic_detect_pkg::ADDR_STATE, 16'h0000, "disabled state");
		// Raised thresholds must reach the comparators and keep both detectors quiet.
		wreg(mic_detect_pkg::ADDR_CTRL, 16'h005E);
		idle(60);
		check({13'h0000, det_thr}, 16'h0005, "detect threshold");
		check({14'h0000, short_thr}, 16'h0003, "short threshold");
		check({15'h0000, det_ena}, 16'h0001, "detect enable");
		rchk(mic_detect_pkg::ADDR_STATE, 16'h0000, "above raised thresholds");
		$display("test mask and enable done");
	endtask

	// Main sequence.
	initial begin
		repeat (10) @(posedge clk_in);
		rst_in <= 0;
		t_reset();
		t_insert();
		t_remove();
		t_hook();
		t_gated();
		t_mask_enable();
		end_of_test();
	end
endmodule // test_mic_detect
